// File: hw/itu_defs.svh
// Constants for the instruction translation buffer tag and entry update block.
// Assumes inclusion by bare name from the design module; the package does not include it.
`ifndef ITU_DEFS_SVH
`define ITU_DEFS_SVH

// Internal register select codes
`define ITU_SEL_TAG      2'h0
`define ITU_SEL_INSTR_TLB_ENTRY_PORT  2'h1
`define ITU_SEL_ITB_HOLD 2'h2
`define ITU_SEL_DATA_TLB_ENTRY_PORT  2'h3

// Staged tag, virtual address bits
`define ITU_TAG_HI       42
`define ITU_TAG_LO       13

// Entry write format
`define ITU_W_PFN_HI     52
`define ITU_W_PFN_LO     32
`define ITU_W_RE_HI      11
`define ITU_W_RE_LO      8
`define ITU_W_ASM        4

// Holding register read format
`define ITU_R_ASM        34
`define ITU_R_PFN_HI     33
`define ITU_R_PFN_LO     13
`define ITU_R_RE_HI      11
`define ITU_R_RE_LO      8

// Reset values
`define ITU_PTR_RST      3'h0
`define ITU_VALID_RST    8'h00
`define ITU_DATA_RST     64'h0000_0000_0000_0000

`endif

// File: hw/itu_itb_update.sv
// Tag staging register and eight-slot instruction translation buffer with
// entry port, read holding register and data buffer fill output.
// Assumes one internal register access per cycle from privileged software;
// mode input comes from logic on the same clock.
//
// Operation
// R1 - Write-only staging register holds next fill tag
// R2 - Tag reaches array only on entry write
// R3 - Slot chosen at entry write by pointer
// R4 - Tag writes honoured only in firmware mode
// R5 - Entry port covers eight readable writable entries
// R6 - Entry write loads slot tag from staging
// R7 - Entry write uses page-table bit positions
// R8 - Entry read is two steps via holding
// R9 - Every entry access advances the pointer
// R10 - Entry port access only in firmware mode
// R11 - Holding register refreshed on reads and writes
// R12 - Staged tag keeps virtual bits 42 to 13
`include "itu_defs.svh"
`default_nettype none

module itu_itb_update
    import itu_pkg::*;
(
    input  wire logic        clock_in,          // 100 MHz clock
    input  wire logic        rst_in,            // Sync reset, high
    input  wire logic        fw_mode_in,        // Privileged firmware mode
    input  wire logic        ipr_wr_en_in,      // Register write strobe
    input  wire logic        ipr_rd_en_in,      // Register read strobe
    input  wire logic [1:0]  ipr_sel_in,        // Register select
    input  wire logic [63:0] ipr_wdata_in,      // Write data
    output logic      [63:0] ipr_rdata_out,     // Read data
    output logic             ipr_rvalid_out,    // Read data valid pulse
    output logic      [2:0]  itb_ptr_out,       // Entry pointer
    output logic      [7:0]  itb_valid_out,     // Valid per slot
    output logic             dtb_fill_out,      // Data buffer fill pulse
    output logic      [29:0] dtb_fill_tag_out,  // Tag for data buffer fill
    output logic      [63:0] dtb_fill_pte_out   // Raw entry for data buffer
);

    itu_tag_t  stage_ff;
    itu_slot_t ptr_ff;
    itu_pte_t  hold_ff;
    itu_tag_t  tag_ff [8];
    itu_pte_t  pte_ff [8];
    logic [7:0] valid_ff;
    logic [63:0] rdata_ff;
    logic        rvalid_ff;
    logic        dfill_ff;
    itu_tag_t    dtag_ff;
    logic [63:0] dpte_ff;

    logic     tag_wr;
    logic     itb_wr;
    logic     itb_rd;
    logic     hold_rd;
    logic     dtb_wr;
    itu_pte_t nxt_pte;
    logic [63:0] hold_rd_w;

    // Privilege enable for kernel mode is deliberately not an input here
    assign tag_wr  = ipr_wr_en_in && fw_mode_in && ipr_sel_in == `ITU_SEL_TAG;      // [R4]
    assign itb_wr  = ipr_wr_en_in && fw_mode_in && ipr_sel_in == `ITU_SEL_INSTR_TLB_ENTRY_PORT;  // [R10]
    assign dtb_wr  = ipr_wr_en_in && fw_mode_in && ipr_sel_in == `ITU_SEL_DATA_TLB_ENTRY_PORT;
    // Write wins if software issues both in one cycle
    assign itb_rd  = ipr_rd_en_in && !ipr_wr_en_in && fw_mode_in
                     && ipr_sel_in == `ITU_SEL_INSTR_TLB_ENTRY_PORT;                           // [R10]
    assign hold_rd = ipr_rd_en_in && fw_mode_in && ipr_sel_in == `ITU_SEL_ITB_HOLD;

    // Unlisted bits of the write format are dropped
    always_comb begin
        nxt_pte.asm_en  = ipr_wdata_in[`ITU_W_ASM];                               // [R7]
        nxt_pte.page_frame_number     = ipr_wdata_in[`ITU_W_PFN_HI:`ITU_W_PFN_LO];              // [R7]
        nxt_pte.read_en = ipr_wdata_in[`ITU_W_RE_HI:`ITU_W_RE_LO];                // [R7]
    end

    always_comb begin
        hold_rd_w = `ITU_DATA_RST;
        hold_rd_w[`ITU_R_ASM] = hold_ff.asm_en;
        hold_rd_w[`ITU_R_PFN_HI:`ITU_R_PFN_LO] = hold_ff.page_frame_number;
        hold_rd_w[`ITU_R_RE_HI:`ITU_R_RE_LO] = hold_ff.read_en;
    end

    // Staging register, never readable
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            stage_ff <= '0;
        end else if (tag_wr) begin
            stage_ff <= ipr_wdata_in[`ITU_TAG_HI:`ITU_TAG_LO];                    // [R1] [R12]
        end
    end

    // Round-robin pointer: never points at the slot just used
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            ptr_ff <= `ITU_PTR_RST;
        end else if (itb_wr || itb_rd) begin
            ptr_ff <= ptr_ff + 3'h1;                                              // [R9] [R3]
        end
    end

    // Holding register follows every entry port access
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            hold_ff <= '0;
        end else if (itb_wr) begin
            hold_ff <= nxt_pte;                                                   // [R11]
        end else if (itb_rd) begin
            hold_ff <= pte_ff[ptr_ff];                                            // [R8] [R11]
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_slot                                 // [R5]
            always_ff @(posedge clock_in) begin
                if (rst_in) begin
                    tag_ff[gi]   <= '0;
                    pte_ff[gi]   <= '0;
                    valid_ff[gi] <= 1'b0;
                end else if (itb_wr && ptr_ff == 3'(gi)) begin                    // [R3]
                    tag_ff[gi]   <= stage_ff;                                     // [R6] [R2]
                    pte_ff[gi]   <= nxt_pte;                                      // [R6]
                    valid_ff[gi] <= 1'b1;
                end
            end

            slot_still_a: assert property (@(posedge clock_in) disable iff (rst_in)
                !(itb_wr && ptr_ff == 3'(gi)) |=> $stable(tag_ff[gi])) // [R2]
                else $error("slot tag changed without entry write");
        end
    endgenerate

    // Read data: entry port reads return zero, data lands in holding first
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            rdata_ff  <= `ITU_DATA_RST;
            rvalid_ff <= 1'b0;
        end else begin
            rvalid_ff <= ipr_rd_en_in;
            rdata_ff  <= hold_rd ? hold_rd_w : `ITU_DATA_RST;                     // [R8]
        end
    end

    // Data buffer gets the staged tag only with its entry write
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            dfill_ff <= 1'b0;
            dtag_ff  <= '0;
            dpte_ff  <= `ITU_DATA_RST;
        end else begin
            dfill_ff <= dtb_wr;                                                   // [R2]
            if (dtb_wr) begin
                dtag_ff <= stage_ff;                                              // [R1]
                dpte_ff <= ipr_wdata_in;
            end
        end
    end

    assign ipr_rdata_out    = rdata_ff;
    assign ipr_rvalid_out   = rvalid_ff;
    assign itb_ptr_out      = ptr_ff;
    assign itb_valid_out    = valid_ff;
    assign dtb_fill_out     = dfill_ff;
    assign dtb_fill_tag_out = dtag_ff;
    assign dtb_fill_pte_out = dpte_ff;

    default clocking cb @(posedge clock_in); endclocking
    default disable iff (rst_in);

    tag_gate_a: assert property ( // [R4]
        ipr_wr_en_in && !fw_mode_in |=> $stable(stage_ff))
        else $error("tag staged outside firmware mode");

    tag_load_a: assert property ( // [R12]
        tag_wr |=> stage_ff == $past(ipr_wdata_in[42:13]))
        else $error("staged tag bits wrong");

    slot_load_a: assert property ( // [R6]
        itb_wr |=> tag_ff[$past(ptr_ff)] == $past(stage_ff)
                   && valid_ff[$past(ptr_ff)])
        else $error("slot not loaded from staging");

    ptr_step_a: assert property ( // [R9]
        itb_wr || itb_rd |=> ptr_ff == $past(ptr_ff) + 3'h1)
        else $error("pointer did not advance");

    ptr_wrap_a: assert property ( // [R9]
        (itb_rd && ptr_ff == 3'h7) |=> ptr_ff == 3'h0)
        else $error("pointer did not wrap over eight");

    mode_gate_a: assert property ( // [R10]
        !fw_mode_in |=> $stable(ptr_ff) && $stable(hold_ff))
        else $error("entry port used outside firmware mode");

    hold_fresh_a: assert property ( // [R11]
        itb_wr |=> hold_ff == $past(nxt_pte))
        else $error("holding not refreshed on write");

    pte_field_a: assert property ( // [R7]
        itb_wr |=> hold_ff.page_frame_number == $past(ipr_wdata_in[52:32])
                   && hold_ff.asm_en == $past(ipr_wdata_in[4]))
        else $error("entry fields misplaced");

    two_read_a: assert property ( // [R8]
        itb_rd ##1 hold_rd |=> ipr_rdata_out[33:13] == $past(hold_ff.page_frame_number)
                               && ipr_rvalid_out)
        else $error("two step read returned wrong data");

    dtb_fill_a: assert property ( // [R2]
        dtb_wr |=> dtb_fill_out && dtb_fill_tag_out == $past(stage_ff))
        else $error("data buffer fill tag wrong");

    // Read side: every strobe answers once, refused or not
    rvalid_pulse_a: assert property ( // [R8]
        ipr_rd_en_in |=> ipr_rvalid_out)
        else $error("read strobe got no valid pulse");

    rvalid_quiet_a: assert property ( // [R8]
        !ipr_rd_en_in |=> !ipr_rvalid_out)
        else $error("valid pulse without read strobe");

    rdata_idle_a: assert property ( // [R8]
        !ipr_rd_en_in |=> ipr_rdata_out == '0)
        else $error("read data not cleared when idle");

    tag_noread_a: assert property ( // [R1]
        ipr_rd_en_in && ipr_sel_in == `ITU_SEL_TAG |=> ipr_rdata_out == '0)
        else $error("staging register readable");

    port_read_zero_a: assert property ( // [R8]
        ipr_rd_en_in && ipr_sel_in == `ITU_SEL_INSTR_TLB_ENTRY_PORT |=> ipr_rdata_out == '0)
        else $error("entry port read bypassed holding");

    hold_read_fmt_a: assert property ( // [R8]
        hold_rd |=> ipr_rdata_out[34] == $past(hold_ff.asm_en)
                    && ipr_rdata_out[11:8] == $past(hold_ff.read_en)
                    && ipr_rdata_out[63:35] == '0 && !ipr_rdata_out[12])
        else $error("holding read format wrong");

    // Holding register is read-only and moves only with the entry port
    hold_ro_a: assert property ( // [R8]
        !(itb_wr || itb_rd) |=> $stable(hold_ff))
        else $error("holding changed without entry access");

    hold_copy_a: assert property ( // [R11]
        itb_rd |=> hold_ff == $past(pte_ff[ptr_ff]))
        else $error("holding not refreshed on read");

    hold_nowrite_a: assert property ( // [R8]
        ipr_wr_en_in && ipr_sel_in == `ITU_SEL_ITB_HOLD
        |=> $stable(stage_ff) && $stable(ptr_ff) && $stable(hold_ff))
        else $error("write to holding changed state");

    wr_wins_a: assert property ( // [R10]
        itb_wr && ipr_rd_en_in |=> hold_ff == $past(nxt_pte))
        else $error("read beat write on same cycle");

    ptr_hold_a: assert property ( // [R3]
        !(itb_wr || itb_rd) |=> $stable(ptr_ff))
        else $error("pointer moved without access");

    stage_keep_a: assert property ( // [R2]
        !tag_wr |=> $stable(stage_ff))
        else $error("staging changed without tag write");

    slot_pte_a: assert property ( // [R6]
        itb_wr |=> pte_ff[$past(ptr_ff)] == $past(nxt_pte))
        else $error("slot entry not loaded");

    enable_field_a: assert property ( // [R7]
        itb_wr |=> hold_ff.read_en == $past(ipr_wdata_in[11:8]))
        else $error("read enable field misplaced");

    valid_set_a: assert property ( // [R5]
        itb_wr |=> valid_ff[$past(ptr_ff)])
        else $error("written slot not valid");

    // No invalidate path, so valid bits only ever rise
    valid_keep_a: assert property ( // [R5]
        1'b1 |=> (valid_ff & $past(valid_ff)) == $past(valid_ff))
        else $error("valid bit cleared");

    dtb_quiet_a: assert property ( // [R2]
        !dtb_wr |=> !dtb_fill_out && $stable(dtb_fill_tag_out)
                    && $stable(dtb_fill_pte_out))
        else $error("data buffer fill without write");

    data_tlb_entry_port_a: assert property ( // [R2]
        dtb_wr |=> dtb_fill_pte_out == $past(ipr_wdata_in))
        else $error("data buffer entry wrong");

endmodule // itu_itb_update

`default_nettype wire

// File: hw/itu_pkg.sv
// Types for the instruction translation buffer tag and entry update block.
// Assumes itu_defs.svh is on the include path.
`default_nettype none

package itu_pkg;
    typedef logic [2:0]  itu_slot_t;
    typedef logic [29:0] itu_tag_t;
    typedef logic [20:0] itu_pfn_t;
    typedef struct packed {
        logic     asm_en;
        itu_pfn_t page_frame_number;
        logic [3:0] read_en;
    } itu_pte_t;
endpackage

`default_nettype wire

// File: verification/itu_itb_update_tb_top.sv
// Self-checking bench for the tag staging and instruction entry port block.
// Assumes itu_pkg and the design compiled first; the bench drives every port.
`default_nettype none

module itu_itb_update_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clock_in = 1'b0;
    logic        rst_in = 1'b1;
    logic        fw_mode_in = 1'b0;
    logic        ipr_wr_en_in = 1'b0;
    logic        ipr_rd_en_in = 1'b0;
    logic [1:0]  ipr_sel_in = 2'h0;
    logic [63:0] ipr_wdata_in = 64'h0;
    logic [63:0] ipr_rdata_out;
    logic        ipr_rvalid_out;
    logic [2:0]  itb_ptr_out;
    logic [7:0]  itb_valid_out;
    logic        dtb_fill_out;
    logic [29:0] dtb_fill_tag_out;
    logic [63:0] dtb_fill_pte_out;
    int          n_errors = 0;
    int          checks = 0;
    typedef struct {
        logic wr; logic rd; logic [1:0] sel; logic [63:0] d; logic [63:0] rdat; logic [2:0] ptr;
    } itu_row_t;
    localparam logic [63:0] TAG0 = 64'h0000_0555_aaaa_5fff;
    localparam logic [63:0] PTE0 = 64'h0015_5555_0000_0a10;
    itu_row_t    rows [5];
    logic [63:0] slot_q [8];
    logic [63:0] d;

    always #5 clock_in = ~clock_in;

    itu_itb_update uut (
        .clock_in, .rst_in, .fw_mode_in, .ipr_wr_en_in, .ipr_rd_en_in, .ipr_sel_in,
        .ipr_wdata_in, .ipr_rdata_out, .ipr_rvalid_out, .itb_ptr_out, .itb_valid_out,
        .dtb_fill_out, .dtb_fill_tag_out, .dtb_fill_pte_out
    );

    // Holding register read layout
    function automatic logic [63:0] fmt(input logic [63:0] p);
        return {29'h0, p[4], p[52:32], 1'b0, p[11:8], 8'h0};
    endfunction

    task automatic chk_data(input string what, input logic [63:0] exp, input logic [63:0] got);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_ctl(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One strobe cycle, then strobes dropped; returns 1 ns after the sampling edge with registered outputs settled
    task automatic op(input logic fw, input logic wr, input logic rd, input logic [1:0] sel,
                      input logic [63:0] wd);
        @(posedge clock_in);
        fw_mode_in <= fw;
        ipr_wr_en_in <= wr;
        ipr_rd_en_in <= rd;
        ipr_sel_in <= sel;
        ipr_wdata_in <= wd;
        @(posedge clock_in);
        ipr_wr_en_in <= 1'b0;
        ipr_rd_en_in <= 1'b0;
        #1;
    endtask

    task automatic final_report;
        $display("Comparisons %0d mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Whole run is well under a thousand cycles
    initial begin
        repeat (5000) @(posedge clock_in);
        n_errors++;
        final_report();
    end

    initial begin
        rows[0] = '{1'b1, 1'b0, 2'h0, TAG0, 64'h0, 3'h0};
        rows[1] = '{1'b1, 1'b0, 2'h1, PTE0, 64'h0, 3'h1};
        rows[2] = '{1'b0, 1'b1, 2'h0, 64'h0, 64'h0, 3'h1};
        rows[3] = '{1'b0, 1'b1, 2'h2, 64'h0, fmt(PTE0), 3'h1};
        rows[4] = '{1'b0, 1'b1, 2'h1, 64'h0, 64'h0, 3'h2};
        repeat (6) @(posedge clock_in);
        rst_in <= 1'b0;
        @(posedge clock_in);
        #1;
        chk_ctl("ptr", 8'h00, {5'h0, itb_ptr_out});
        chk_ctl("valid", 8'h00, itb_valid_out);
        foreach (rows[i]) begin
            op(1'b1, rows[i].wr, rows[i].rd, rows[i].sel, rows[i].d);
            chk_ctl("rvalid", {7'h0, rows[i].rd}, {7'h0, ipr_rvalid_out});
            chk_data("rdata", rows[i].rdat, ipr_rdata_out);
            chk_ctl("ptr", {5'h0, rows[i].ptr}, {5'h0, itb_ptr_out});
        end
        chk_ctl("valid", 8'h01, itb_valid_out);
        for (int k = 0; k < 8; k++) begin
            d = {11'h0, 21'(k + 3), 20'h0, 4'(k), 3'h0, 1'(k), 4'h0};
            slot_q[(2 + k) % 8] = d;
            op(1'b1, 1'b1, 1'b0, 2'h1, d);
            chk_ctl("ptr", 8'((3 + k) % 8), {5'h0, itb_ptr_out});
        end
        chk_ctl("valid", 8'hff, itb_valid_out);
        for (int k = 0; k < 8; k++) begin
            op(1'b1, 1'b0, 1'b1, 2'h1, 64'h0);
            chk_data("rdata", 64'h0, ipr_rdata_out);
            op(1'b1, 1'b0, 1'b1, 2'h2, 64'h0);
            chk_data("rdata", fmt(slot_q[(2 + k) % 8]), ipr_rdata_out);
        end
        // Refused accesses outside firmware mode, then data buffer fills in firmware mode
        op(1'b0, 1'b1, 1'b0, 2'h1, 64'hffff_ffff_ffff_ffff);
        op(1'b0, 1'b0, 1'b1, 2'h1, 64'h0);
        chk_ctl("ptr", 8'h02, {5'h0, itb_ptr_out});
        op(1'b0, 1'b0, 1'b1, 2'h2, 64'h0);
        chk_ctl("rvalid", 8'h01, {7'h0, ipr_rvalid_out});
        chk_data("rdata", 64'h0, ipr_rdata_out);
        op(1'b0, 1'b1, 1'b0, 2'h0, 64'h0000_07ff_ffff_ffff);
        op(1'b1, 1'b1, 1'b0, 2'h3, 64'h1234_5678_9abc_def0);
        chk_ctl("fill", 8'h01, {7'h0, dtb_fill_out});
        chk_data("tag", {34'h0, TAG0[42:13]}, {34'h0, dtb_fill_tag_out});
        chk_data("pte", 64'h1234_5678_9abc_def0, dtb_fill_pte_out);
        op(1'b1, 1'b1, 1'b0, 2'h0, 64'hfff8_0000_0000_1fff);
        chk_ctl("fill", 8'h00, {7'h0, dtb_fill_out});
        op(1'b1, 1'b1, 1'b0, 2'h3, 64'h0);
        chk_data("tag", 64'h0, {34'h0, dtb_fill_tag_out});
        chk_ctl("ptr", 8'h02, {5'h0, itb_ptr_out});
        // Entry read closely followed by holding read
        @(posedge clock_in);
        fw_mode_in <= 1'b1;
        ipr_rd_en_in <= 1'b1;
        ipr_sel_in <= 2'h1;
        @(posedge clock_in);
        ipr_sel_in <= 2'h2;
        @(posedge clock_in);
        ipr_rd_en_in <= 1'b0;
        #1;
        chk_data("rdata", fmt(slot_q[2]), ipr_rdata_out);
        chk_ctl("ptr", 8'h03, {5'h0, itb_ptr_out});
        final_report();
    end
endmodule // itu_itb_update_tb_top

`default_nettype wire
